// file: pkg/sbst_pkg.sv
package sbst_pkg;
  localparam int IR_W = 3;
  localparam int ID_W = 32;
  // Instruction codes
  localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
  localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
  localparam logic [IR_W-1:0] INS_SAMPLE_Z = 3'h2;
  localparam logic [IR_W-1:0] INS_RSV_A = 3'h3;
  localparam logic [IR_W-1:0] INS_SAMPLE = 3'h4;
  localparam logic [IR_W-1:0] INS_VENDOR = 3'h5;
  localparam logic [IR_W-1:0] INS_RSV_B = 3'h6;
  localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;
  // Pattern loaded into the two low instruction bits on capture
  localparam logic [1:0] IR_CAPT_LOW = 2'h1;
  localparam logic IR_CAPT_HIGH = 1'h0;
  // Value of boundary cells with no pin behind them
  localparam logic BSR_FIX_VAL = 1'h1;
  localparam logic BYP_CAPT_VAL = 1'h0;
  // Arbitrary identification value, bit 0 set as the scan standard expects
  localparam logic [ID_W-1:0] ID_CODE_DEF = 32'h5a5a_c3a1;

  typedef enum logic [15:0] {
    ST_TLR    = 16'h0001,
    ST_IDLE   = 16'h0002,
    ST_SELDR  = 16'h0004,
    ST_CAPDR  = 16'h0008,
    ST_SHDR   = 16'h0010,
    ST_EX1DR  = 16'h0020,
    ST_PSDR   = 16'h0040,
    ST_EX2DR  = 16'h0080,
    ST_UPDDR  = 16'h0100,
    ST_SELIR  = 16'h0200,
    ST_CAPIR  = 16'h0400,
    ST_SHIR   = 16'h0800,
    ST_EX1IR  = 16'h1000,
    ST_PSIR   = 16'h2000,
    ST_EX2IR  = 16'h4000,
    ST_UPDIR  = 16'h8000
  } sbst_tap_st_t;
endpackage

// file: core/sbst_tap.sv
`timescale 1ns/1ps
module sbst_tap #(
  parameter int PIN_W = 8,
  parameter int DQ_W = 4,
  parameter int FIX_W = 2,
  parameter logic [sbst_pkg::ID_W-1:0] ID_CODE = sbst_pkg::ID_CODE_DEF
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  input wire logic [PIN_W-1:0] pad_in_i,
  input wire logic [DQ_W-1:0] core_dout_i,
  input wire logic [DQ_W-1:0] core_doe_i,
  output logic [DQ_W-1:0] pad_dout_o,
  output logic [DQ_W-1:0] pad_doe_o
);
  import sbst_pkg::*;

  localparam int BSR_W = PIN_W + FIX_W;

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;
    sbst_tap_st_t st;
    logic [IR_W-1:0] ir_sh;
    logic [ID_W-1:0] dr_id;
    logic byp;
    logic [BSR_W-1:0] bsr;
  } sbst_pos_t;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
    logic [IR_W-1:0] ir_act;
    logic ext_lvl;
    logic hiz_lvl;
    logic [DQ_W-1:0] upd;
    logic tog;
  } sbst_neg_t;

  typedef struct packed {
    logic ext_s1;
    logic ext_s2;
    logic hiz_s1;
    logic hiz_s2;
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;
    logic [DQ_W-1:0] drv;
    logic [DQ_W-1:0] dout;
    logic [DQ_W-1:0] doe;
  } sbst_core_t;

  sbst_pos_t p_ff, nxt_p;
  sbst_neg_t n_ff, nxt_n;
  sbst_core_t c_ff, nxt_c;

  logic sel_id;
  logic sel_bsr;

  // Data register selection from the active instruction
  always_comb begin
    sel_id = (n_ff.ir_act == INS_IDCODE);
    sel_bsr = (n_ff.ir_act == INS_EXTEST) || (n_ff.ir_act == INS_SAMPLE) ||
              (n_ff.ir_act == INS_SAMPLE_Z);
  end

  // Rising TCK side: controller, shift registers, captures
  always_comb begin
    nxt_p = p_ff;
    nxt_p.rst_s1 = sys_rst_i;
    nxt_p.rst_s2 = p_ff.rst_s1;
    nxt_p.pin_s1 = pad_in_i;
    nxt_p.pin_s2 = p_ff.pin_s1;
    unique case (p_ff.st)
      ST_TLR:   nxt_p.st = tms_i ? ST_TLR : ST_IDLE;
      ST_IDLE:  nxt_p.st = tms_i ? ST_SELDR : ST_IDLE;
      ST_SELDR: nxt_p.st = tms_i ? ST_SELIR : ST_CAPDR;
      ST_CAPDR: nxt_p.st = tms_i ? ST_EX1DR : ST_SHDR;
      ST_SHDR:  nxt_p.st = tms_i ? ST_EX1DR : ST_SHDR;
      ST_EX1DR: nxt_p.st = tms_i ? ST_UPDDR : ST_PSDR;
      ST_PSDR:  nxt_p.st = tms_i ? ST_EX2DR : ST_PSDR;
      ST_EX2DR: nxt_p.st = tms_i ? ST_UPDDR : ST_SHDR;
      ST_UPDDR: nxt_p.st = tms_i ? ST_SELDR : ST_IDLE;
      ST_SELIR: nxt_p.st = tms_i ? ST_TLR : ST_CAPIR;
      ST_CAPIR: nxt_p.st = tms_i ? ST_EX1IR : ST_SHIR;
      ST_SHIR:  nxt_p.st = tms_i ? ST_EX1IR : ST_SHIR;
      ST_EX1IR: nxt_p.st = tms_i ? ST_UPDIR : ST_PSIR;
      ST_PSIR:  nxt_p.st = tms_i ? ST_EX2IR : ST_PSIR;
      ST_EX2IR: nxt_p.st = tms_i ? ST_UPDIR : ST_SHIR;
      ST_UPDIR: nxt_p.st = tms_i ? ST_SELDR : ST_IDLE;
      default:  nxt_p.st = ST_TLR;
    endcase
    if (p_ff.st == ST_CAPIR) begin
      nxt_p.ir_sh = {IR_CAPT_HIGH, IR_CAPT_LOW};
    end else if (p_ff.st == ST_SHIR) begin
      nxt_p.ir_sh = {tdi_i, p_ff.ir_sh[IR_W-1:1]};
    end
    if (p_ff.st == ST_CAPDR) begin
      nxt_p.byp = BYP_CAPT_VAL;
      if (sel_id) begin
        nxt_p.dr_id = ID_CODE;
      end
      if (sel_bsr) begin
        nxt_p.bsr = {{FIX_W{BSR_FIX_VAL}}, p_ff.pin_s2};
      end
    end else if (p_ff.st == ST_SHDR) begin
      if (sel_id) begin
        nxt_p.dr_id = {tdi_i, p_ff.dr_id[ID_W-1:1]};
      end else if (sel_bsr) begin
        nxt_p.bsr = {tdi_i, p_ff.bsr[BSR_W-1:1]};
      end else begin
        nxt_p.byp = tdi_i;
      end
    end
    if (p_ff.rst_s2) begin
      nxt_p.st = ST_TLR;
      nxt_p.ir_sh = INS_IDCODE;
      nxt_p.dr_id = '0;
      nxt_p.byp = BYP_CAPT_VAL;
      nxt_p.bsr = '0;
    end
  end

  // Falling TCK side: active instruction, serial output, update latch
  always_comb begin
    nxt_n = n_ff;
    nxt_n.tdo_oe = (p_ff.st == ST_SHIR) || (p_ff.st == ST_SHDR);
    if (p_ff.st == ST_SHIR) begin
      nxt_n.tdo = p_ff.ir_sh[0];
    end else if (p_ff.st == ST_SHDR) begin
      if (sel_id) begin
        nxt_n.tdo = p_ff.dr_id[0];
      end else if (sel_bsr) begin
        nxt_n.tdo = p_ff.bsr[0];
      end else begin
        nxt_n.tdo = p_ff.byp;
      end
    end
    if (p_ff.st == ST_TLR) begin
      nxt_n.ir_act = INS_IDCODE;
    end else if (p_ff.st == ST_UPDIR) begin
      nxt_n.ir_act = p_ff.ir_sh;
      if (p_ff.ir_sh == INS_EXTEST) begin
        nxt_n.upd = p_ff.bsr[DQ_W-1:0];
        nxt_n.tog = ~n_ff.tog;
      end
    end else if ((p_ff.st == ST_UPDDR) && sel_bsr) begin
      nxt_n.upd = p_ff.bsr[DQ_W-1:0];
      nxt_n.tog = ~n_ff.tog;
    end
    nxt_n.ext_lvl = (nxt_n.ir_act == INS_EXTEST);
    nxt_n.hiz_lvl = (nxt_n.ir_act == INS_SAMPLE_Z);
    if (p_ff.rst_s2) begin
      nxt_n = '0;
      nxt_n.ir_act = INS_IDCODE;
    end
  end

  // Core clock side: output driver override
  always_comb begin
    nxt_c = c_ff;
    nxt_c.ext_s1 = n_ff.ext_lvl;
    nxt_c.ext_s2 = c_ff.ext_s1;
    nxt_c.hiz_s1 = n_ff.hiz_lvl;
    nxt_c.hiz_s2 = c_ff.hiz_s1;
    nxt_c.tog_s1 = n_ff.tog;
    nxt_c.tog_s2 = c_ff.tog_s1;
    nxt_c.tog_s3 = c_ff.tog_s2;
    if (c_ff.tog_s2 != c_ff.tog_s3) begin
      nxt_c.drv = n_ff.upd;
    end
    // Inputs are never gated; only the output drivers are overridden
    if (c_ff.hiz_s2) begin
      nxt_c.dout = core_dout_i;
      nxt_c.doe = '0;
    end else if (c_ff.ext_s2) begin
      nxt_c.dout = c_ff.drv;
      nxt_c.doe = '1;
    end else begin
      nxt_c.dout = core_dout_i;
      nxt_c.doe = core_doe_i;
    end
    if (sys_rst_i) begin
      nxt_c = '0;
    end
  end

  always_ff @(posedge tck_i) begin
    p_ff <= nxt_p;
  end

  always_ff @(negedge tck_i) begin
    n_ff <= nxt_n;
  end

  always_ff @(posedge core_clk_i) begin
    c_ff <= nxt_c;
  end

  always_comb begin
    tdo_o = n_ff.tdo;
    tdo_oe_o = n_ff.tdo_oe;
    pad_dout_o = c_ff.dout;
    pad_doe_o = c_ff.doe;
  end

  capt_ir_a: assert property (@(posedge tck_i) disable iff (p_ff.rst_s2)
    (p_ff.st == ST_CAPIR) |=> (p_ff.ir_sh[1:0] == IR_CAPT_LOW))
    else $error("capture-IR pattern wrong");

  id_capture_a: assert property (@(posedge tck_i) disable iff (p_ff.rst_s2)
    (p_ff.st == ST_CAPDR) && sel_id |=> (p_ff.dr_id == ID_CODE))
    else $error("identification value not captured");

  id_shift_a: assert property (@(posedge tck_i) disable iff (p_ff.rst_s2)
    (p_ff.st == ST_SHDR) && sel_id |-> (tdo_o == p_ff.dr_id[0]))
    else $error("identification bit order wrong");

  tms_reset_a: assert property (@(posedge tck_i) disable iff (p_ff.rst_s2)
    tms_i [*5] |=> (p_ff.st == ST_TLR))
    else $error("five TMS highs did not reset controller");

  tdo_float_a: assert property (@(posedge tck_i) disable iff (p_ff.rst_s2)
    tdo_oe_o == ((p_ff.st == ST_SHIR) || (p_ff.st == ST_SHDR)))
    else $error("serial output enable wrong");

  ir_hold_a: assert property (@(posedge tck_i) disable iff (p_ff.rst_s2)
    $changed(n_ff.ir_act) |-> ((p_ff.st == ST_UPDIR) || (p_ff.st == ST_TLR)))
    else $error("instruction changed outside update");

  bypass_path_a: assert property (@(posedge tck_i) disable iff (p_ff.rst_s2)
    (p_ff.st == ST_SHDR) && !sel_id && !sel_bsr |-> (tdo_o == p_ff.byp))
    else $error("bypass bit not on serial output");

  bsr_capture_a: assert property (@(posedge tck_i) disable iff (p_ff.rst_s2)
    (p_ff.st == ST_CAPDR) && sel_bsr |=>
      (p_ff.bsr == {{FIX_W{BSR_FIX_VAL}}, $past(p_ff.pin_s2)}))
    else $error("boundary capture wrong");

  hiz_force_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    c_ff.hiz_s2 |=> (pad_doe_o == '0))
    else $error("outputs not forced off");

  extest_drive_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    c_ff.ext_s2 && !c_ff.hiz_s2 |=> (pad_doe_o == '1) && (pad_dout_o == $past(c_ff.drv)))
    else $error("external test drive wrong");

  // Instruction path and controller checks
  ir_update_a: assert property (@(posedge tck_i) disable iff (p_ff.rst_s2)
    (p_ff.st == ST_UPDIR) |-> (n_ff.ir_act == p_ff.ir_sh))
    else $error("instruction not taken at update");

  tlr_instr_a: assert property (@(posedge tck_i) disable iff (p_ff.rst_s2)
    (p_ff.st == ST_TLR) |-> (n_ff.ir_act == INS_IDCODE))
    else $error("reset state lost identification instruction");

  ir_shift_a: assert property (@(posedge tck_i) disable iff (p_ff.rst_s2)
    (p_ff.st == ST_SHIR) |=> (p_ff.ir_sh == {$past(tdi_i), $past(p_ff.ir_sh[IR_W-1:1])}))
    else $error("instruction shift wrong");

  ir_tdo_a: assert property (@(posedge tck_i) disable iff (p_ff.rst_s2)
    (p_ff.st == ST_SHIR) |-> (tdo_o == p_ff.ir_sh[0]))
    else $error("instruction bit not on serial output");

  tlr_exit_a: assert property (@(posedge tck_i) disable iff (p_ff.rst_s2)
    (p_ff.st == ST_TLR) && !tms_i |=> (p_ff.st == ST_IDLE))
    else $error("controller did not leave reset state");

  // Data register checks
  id_shift_in_a: assert property (@(posedge tck_i) disable iff (p_ff.rst_s2)
    (p_ff.st == ST_SHDR) && sel_id |=>
      (p_ff.dr_id == {$past(tdi_i), $past(p_ff.dr_id[ID_W-1:1])}))
    else $error("identification shift wrong");

  byp_capture_a: assert property (@(posedge tck_i) disable iff (p_ff.rst_s2)
    (p_ff.st == ST_CAPDR) && !sel_id && !sel_bsr |=> (p_ff.byp == BYP_CAPT_VAL))
    else $error("bypass capture wrong");

  byp_shift_a: assert property (@(posedge tck_i) disable iff (p_ff.rst_s2)
    (p_ff.st == ST_SHDR) && !sel_id && !sel_bsr |=> (p_ff.byp == $past(tdi_i)))
    else $error("bypass shift wrong");

  bsr_shift_a: assert property (@(posedge tck_i) disable iff (p_ff.rst_s2)
    (p_ff.st == ST_SHDR) && sel_bsr |=>
      (p_ff.bsr == {$past(tdi_i), $past(p_ff.bsr[BSR_W-1:1])}))
    else $error("boundary shift wrong");

  bsr_tdo_a: assert property (@(posedge tck_i) disable iff (p_ff.rst_s2)
    (p_ff.st == ST_SHDR) && sel_bsr |-> (tdo_o == p_ff.bsr[0]))
    else $error("boundary bit not on serial output");

  ext_update_a: assert property (@(posedge tck_i) disable iff (p_ff.rst_s2)
    (p_ff.st == ST_UPDIR) && (p_ff.ir_sh == INS_EXTEST) |->
      (n_ff.upd == p_ff.bsr[DQ_W-1:0]))
    else $error("update word not latched");

  // Output driver checks
  pass_thru_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !c_ff.hiz_s2 && !c_ff.ext_s2 |=>
      (pad_doe_o == $past(core_doe_i)) && (pad_dout_o == $past(core_dout_i)))
    else $error("core outputs not passed through");

  drv_load_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (c_ff.tog_s2 != c_ff.tog_s3) |=> (c_ff.drv == $past(n_ff.upd)))
    else $error("drive word not taken");

  hiz_data_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    c_ff.hiz_s2 |=> (pad_dout_o == $past(core_dout_i)))
    else $error("data path disturbed while floating");

  ext_level_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    c_ff.ext_s1 |=> c_ff.ext_s2)
    else $error("external test level not synchronised");
endmodule

// file: bench/sbst_scan_ctl.sv
`timescale 1ns/1ps
module sbst_scan_ctl (
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i
);
  // Test clock stands still low between frames
  initial begin
    tck_o = 1'h0;
    tms_o = 1'h1;
    tdi_o = 1'h1;
  end
  // Mode and data change while the clock is low, output taken before each rise
  task automatic run(input logic [47:0] tms, input logic [47:0] tdi, input int n,
                     output logic [47:0] td);
    td = '0;
    for (int i = 0; i < n; i++) begin
      tms_o = tms[i];
      tdi_o = tdi[i];
      #8;
      td[i] = tdo_i;
      #8 tck_o = 1'h1;
      #16 tck_o = 1'h0;
    end
    #8;
  endtask
endmodule

// file: bench/sbst_tap_bench.sv
`timescale 1ns/1ps
module sbst_tap_bench;
  import sbst_pkg::*;
  logic core_clk_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic tck, tms, tdi, tdo, tdo_oe;
  logic [7:0] pad_in = 8'h00;
  logic [3:0] cdout = 4'h9;
  logic [3:0] cdoe = 4'h6;
  logic [3:0] pdout, pdoe;
  logic [47:0] td;
  logic [2:0] bp [4] = '{INS_RSV_A, INS_VENDOR, INS_RSV_B, INS_BYPASS};
  int fail_count = 0;
  int checks = 0;
  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end
  sbst_tap i_dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .tck_i(tck),
    .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .pad_in_i(pad_in),
    .core_dout_i(cdout), .core_doe_i(cdoe), .pad_dout_o(pdout), .pad_doe_o(pdoe));
  sbst_scan_ctl i_ctl (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));
  task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic settle();
    repeat (10) @(posedge core_clk_i);
  endtask
  // Codes as written, MSB left, shifted LSB first
  task automatic ir(input logic [2:0] code, output logic [2:0] old);
    i_ctl.run(48'h0c3, {41'h0, code, 4'h0}, 9, td);
    old = td[6:4];
    settle();
  endtask
  task automatic dr(input int n, input logic [47:0] din, output logic [47:0] q);
    i_ctl.run(48'h1 | (48'h3 << (n + 2)), din << 3, n + 5, td);
    q = (td >> 3) & ((48'h1 << n) - 48'h1);
    settle();
  endtask
  task automatic pads(input logic [7:0] p);
    @(posedge core_clk_i);
    pad_in <= p;
  endtask
  task automatic close_out();
    $display("Counts: %0d checks, %0d mismatches", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    logic [2:0] old;
    logic [47:0] q;
    #3;
    i_ctl.run(48'hff, 48'h0, 8, td);
    @(posedge core_clk_i);
    sys_rst_i <= 1'h0;
    i_ctl.run(48'h07, 48'h0, 4, td);
    dr(32, 48'h0, q);
    chk("idcode", q, {16'h0, ID_CODE_DEF});
    $display("test idcode done");
    foreach (bp[i]) begin
      ir(bp[i], old);
      chk("ir_capture", old, 3'h1);
      dr(8, 48'ha5, q);
      chk("bypass", q, 48'h4a);
      chk("pads_pass", {pdoe, pdout}, {cdoe, cdout});
    end
    $display("test bypass done");
    pads(8'h96); // Pins held stable well before capture
    ir(INS_SAMPLE, old);
    dr(10, 48'h2a5, q);
    chk("sample", q, 48'h396);
    chk("sample_pads", {pdoe, pdout}, {cdoe, cdout});
    $display("test sample done");
    ir(INS_SAMPLE_Z, old);
    chk("hiz_oe", pdoe, 4'h0);
    dr(10, 48'h00a, q);
    chk("hiz_capture", q, 48'h396);
    $display("test sample_z done");
    i_ctl.run(48'h43, 48'h0, 7, td);
    settle();
    chk("old_instr", pdoe, 4'h0);
    i_ctl.run(48'h1, 48'h0, 2, td);
    settle();
    chk("extest_oe", pdoe, 4'hf);
    chk("extest_word", pdout, 4'ha);
    pads(8'h3c);
    settle();
    dr(10, 48'h003, q);
    chk("extest_capture", q, 48'h33c);
    chk("extest_update", pdout, 4'h3);
    chk("tdo_idle", tdo_oe, 1'h0);
    $display("test extest done");
    ir(INS_BYPASS, old);
    i_ctl.run(48'h1f, 48'h0, 6, td); // Five mode-high edges
    settle();
    chk("reset_pads", {pdoe, pdout}, {cdoe, cdout});
    dr(32, 48'h0, q);
    chk("reset_idcode", q, {16'h0, ID_CODE_DEF});
    $display("test mode reset done");
    close_out();
  end
endmodule
